// [pkg/hpf_pkg.sv]
package hpf_pkg;

  // Pin counts and widths
  localparam int HPF_NPINS       = 6;   // Shared pins gp_pin_10 .. gp_pin_15
  localparam int HPF_DATA_W      = 8;   // Host data lines
  localparam int HPF_SYNC_STAGES = 2;   // Flops in each input synchroniser

  // Position of each shared pin inside the pin vectors
  localparam int HPF_PIN_ADDR = 0;      // gp_pin_10: addr line two / nine
  localparam int HPF_PIN_RW   = 1;      // gp_pin_11: read_not_write / read strobe
  localparam int HPF_PIN_DS   = 2;      // gp_pin_12: data strobe / write strobe
  localparam int HPF_PIN_CS   = 3;      // gp_pin_13: chip select / addr line ten
  localparam int HPF_PIN_REQ  = 4;      // gp_pin_14: service / transmit request
  localparam int HPF_PIN_ACK  = 5;      // gp_pin_15: acknowledge / receive request

  // Polarity encoding: 0 is active low, 1 is active high
  localparam logic HPF_POL_LOW = 1'b0;  // Reset polarity of every strobe

  // General-purpose pin direction
  typedef enum logic [1:0] {
    HPF_GP_OFF,                         // Disconnected: no drive, no sampling
    HPF_GP_IN,                          // Sampled input
    HPF_GP_OUT                          // Driven output
  } hpf_gp_dir_t;

  // Configuration word, loaded by the core
  typedef struct packed {
    logic                         host_fn;     // Host function selected
    logic                         mux_bus;     // Multiplexed host bus
    logic                         dual_strobe; // Separate read and write strobes
    logic                         dual_req;    // Transmit and receive requests
    logic                         rd_pol;      // Read strobe polarity
    logic                         wr_pol;      // Write strobe polarity
    logic                         ds_pol;      // Data strobe polarity
    logic                         cs_pol;      // Chip select polarity
    logic                         as_pol;      // Address strobe polarity
    logic                         req_pol;     // Request output polarity
    logic                         ack_pol;     // Acknowledge polarity
    logic                         req_od;      // Requests are open drain
    hpf_gp_dir_t [HPF_NPINS-1:0]  gp_dir;      // Per-pin direction
    logic [HPF_NPINS-1:0]         gp_out;      // Per-pin output value
  } hpf_cfg_t;

  // Reset configuration: GPIO, all disconnected, all polarities active low
  localparam hpf_cfg_t HPF_CFG_RST = '0;

  // Decoded host activity, seen by the core
  typedef struct packed {
    logic                  sel;        // Chip selected (always in muxed mode)
    logic                  rd;         // Host read access in progress
    logic                  wr;         // Host write access in progress
    logic                  ack;        // Acknowledge asserted
    logic                  rnw;        // Read_not_write level
    logic                  addr_two;   // Address line two
    logic                  addr_nine;  // Address line nine
    logic                  addr_ten;   // Address line ten
    logic [HPF_DATA_W-1:0] mux_addr;   // Latched multiplexed address byte
  } hpf_host_t;

endpackage

// [hdl/hpf_sync.sv]
`timescale 1ns/100ps
module hpf_sync #(
  parameter int W = 1                   // Number of bits synchronised
) (
  input  wire logic         sys_clk,    // System clock
  input  wire logic         reset,      // Synchronous reset, active high
  input  wire logic [W-1:0] async_in,   // Asynchronous host levels
  output logic      [W-1:0] sync_out    // Levels in the clock domain
);
  import hpf_pkg::*;

  logic [W-1:0] stage_q [HPF_SYNC_STAGES];  // Synchroniser chain

  // Shift chain; the first stage feeds only the next stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int k = 0; k < HPF_SYNC_STAGES; k++) stage_q[k] <= '0;
    end else begin
      stage_q[0] <= async_in;
      for (int k = 1; k < HPF_SYNC_STAGES; k++) stage_q[k] <= stage_q[k-1];
    end
  end

  assign sync_out = stage_q[HPF_SYNC_STAGES-1];

endmodule // hpf_sync

// [hdl/hpf_pin_select.sv]
`timescale 1ns/100ps
module hpf_pin_select (
  input  wire logic                          sys_clk,      // 20 MHz system clock
  input  wire logic                          reset,        // Synchronous reset
  input  wire logic                          cfg_wr,       // Load cfg_in this cycle
  input  wire hpf_pkg::hpf_cfg_t             cfg_in,       // New configuration
  output hpf_pkg::hpf_cfg_t                  cfg_q,        // Current configuration
  input  wire logic                          core_req,     // Service request
  input  wire logic                          core_tx_req,  // Transmit request
  input  wire logic                          core_rx_req,  // Receive request
  input  wire logic [hpf_pkg::HPF_DATA_W-1:0] core_rd_data, // Data for host reads
  output hpf_pkg::hpf_host_t                 host_st,      // Decoded host activity
  output logic [hpf_pkg::HPF_DATA_W-1:0]     host_wdata,   // Data from host writes
  output logic [hpf_pkg::HPF_NPINS-1:0]      gp_in_q,      // Sampled GPIO inputs
  input  wire logic [hpf_pkg::HPF_NPINS-1:0] pin_in,       // Shared pin levels
  output logic [hpf_pkg::HPF_NPINS-1:0]      pin_out,      // Shared pin drive value
  output logic [hpf_pkg::HPF_NPINS-1:0]      pin_oe_n,     // Low while driving
  input  wire logic [hpf_pkg::HPF_DATA_W-1:0] dat_in,      // Data pin levels
  output logic [hpf_pkg::HPF_DATA_W-1:0]     dat_out,      // Data pin drive value
  output logic [hpf_pkg::HPF_DATA_W-1:0]     dat_oe_n,     // Low while driving
  input  wire logic                          as_in         // Address strobe pin
);
  import hpf_pkg::*;

  localparam int SW = HPF_NPINS + HPF_DATA_W + 1;  // Synchronised width

  logic [SW-1:0]          raw_in;        // All host-driven inputs
  logic [SW-1:0]          syn_in;        // Synchronised copy
  logic [HPF_NPINS-1:0]   pin_s;         // Synchronised shared pins
  logic [HPF_DATA_W-1:0]  dat_s;         // Synchronised data pins
  logic                   as_s;          // Synchronised address strobe
  logic                   host;          // Host function selected
  logic                   rd_act;        // Read strobe asserted
  logic                   wr_act;        // Write strobe asserted
  logic                   ds_act;        // Data strobe asserted
  logic                   cs_act;        // Chip select asserted
  logic                   as_act;        // Address strobe asserted
  logic                   ack_act;       // Acknowledge asserted
  logic                   cs_ok;         // Selected for this access
  logic                   acc_rd;        // Read access decoded
  logic                   acc_wr;        // Write access decoded
  logic                   req_a;         // Request on the request pin
  logic                   lvl_a;         // Pin level for req_a
  logic                   lvl_b;         // Pin level for receive request
  logic [HPF_NPINS-1:0]   hst_out;       // Host-mode drive values
  logic [HPF_NPINS-1:0]   hst_oe_n;      // Host-mode enables
  logic [HPF_NPINS-1:0]   gp_out_d;      // GPIO drive values
  logic [HPF_NPINS-1:0]   gp_oe_n_d;     // GPIO enables
  logic [HPF_NPINS-1:0]   gp_in_d;       // GPIO sampled values
  logic [HPF_NPINS-1:0]   pin_out_d;     // Next pin drive value
  logic [HPF_NPINS-1:0]   pin_oe_n_d;    // Next pin enable
  hpf_host_t              host_d;        // Next decoded host activity

  // Every host-driven level passes the synchroniser first
  assign raw_in = {as_in, dat_in, pin_in};
  hpf_sync #(.W(SW)) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (raw_in),
    .sync_out (syn_in)
  );
  assign pin_s = syn_in[HPF_NPINS-1:0];
  assign dat_s = syn_in[HPF_NPINS+HPF_DATA_W-1:HPF_NPINS];
  assign as_s  = syn_in[SW-1];

  // Configuration register; reset gives GPIO, disconnected, active low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_q <= HPF_CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= cfg_in;
    end
  end

  assign host = cfg_q.host_fn;

  // Active levels: a pin is asserted when it equals its polarity bit
  assign rd_act  = pin_s[HPF_PIN_RW]  ~^ cfg_q.rd_pol;
  assign wr_act  = pin_s[HPF_PIN_DS]  ~^ cfg_q.wr_pol;
  assign ds_act  = pin_s[HPF_PIN_DS]  ~^ cfg_q.ds_pol;
  assign cs_act  = pin_s[HPF_PIN_CS]  ~^ cfg_q.cs_pol;
  assign as_act  = as_s               ~^ cfg_q.as_pol;
  assign ack_act = pin_s[HPF_PIN_ACK] ~^ cfg_q.ack_pol;

  // Chip select only exists on the non-multiplexed bus
  assign cs_ok = cfg_q.mux_bus | cs_act;

  // Access decode for the two strobe schemes
  assign acc_rd = host & cs_ok &
                  (cfg_q.dual_strobe ? rd_act : (ds_act & pin_s[HPF_PIN_RW]));
  assign acc_wr = host & cs_ok &
                  (cfg_q.dual_strobe ? wr_act : (ds_act & ~pin_s[HPF_PIN_RW]));

  // Decoded host activity for the core
  always_comb begin
    host_d           = host_st;
    host_d.sel       = host & cs_ok;
    host_d.rd        = acc_rd;
    host_d.wr        = acc_wr;
    host_d.ack       = host & ~cfg_q.dual_req & ack_act;
    host_d.rnw       = host & ~cfg_q.dual_strobe & pin_s[HPF_PIN_RW];
    host_d.addr_two  = host & ~cfg_q.mux_bus & pin_s[HPF_PIN_ADDR];
    host_d.addr_nine = host &  cfg_q.mux_bus & pin_s[HPF_PIN_ADDR];
    host_d.addr_ten  = host &  cfg_q.mux_bus & pin_s[HPF_PIN_CS];
    if (host & cfg_q.mux_bus & as_act) begin
      host_d.mux_addr = dat_s;
    end
  end

  // Request pins: pick the source, then apply polarity
  assign req_a = cfg_q.dual_req ? core_tx_req : core_req;
  assign lvl_a = cfg_q.req_pol ? req_a : ~req_a;
  assign lvl_b = cfg_q.req_pol ? core_rx_req : ~core_rx_req;

  // Host-mode pins: four inputs, then the request pins
  assign hst_out[HPF_PIN_CS:0]  = '0;
  assign hst_oe_n[HPF_PIN_CS:0] = '1;
  // Open drain pulls low only; driven mode drives both levels
  assign hst_out[HPF_PIN_REQ]  = cfg_q.req_od ? 1'b0 : lvl_a;
  assign hst_oe_n[HPF_PIN_REQ] = cfg_q.req_od ? lvl_a : 1'b0;
  // Last pin: acknowledge input, or receive request output
  assign hst_out[HPF_PIN_ACK]  = cfg_q.dual_req & ~cfg_q.req_od & lvl_b;
  assign hst_oe_n[HPF_PIN_ACK] = ~cfg_q.dual_req |
                                 (cfg_q.req_od & lvl_b);

  // GPIO view of each pin
  for (genvar i = 0; i < HPF_NPINS; i++) begin : g_gp
    assign gp_out_d[i]  = (cfg_q.gp_dir[i] == HPF_GP_OUT) & cfg_q.gp_out[i];
    assign gp_oe_n_d[i] = (cfg_q.gp_dir[i] != HPF_GP_OUT);
    assign gp_in_d[i]   = ~host & (cfg_q.gp_dir[i] == HPF_GP_IN) & pin_s[i];
  end

  // Function select between host and GPIO
  assign pin_out_d  = host ? hst_out : gp_out_d;
  assign pin_oe_n_d = host ? hst_oe_n : gp_oe_n_d;

  // Pin and status registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
      gp_in_q  <= '0;
      host_st  <= '0;
    end else begin
      pin_out  <= host ? pin_out_d : (~gp_oe_n_d & gp_out_d);
      pin_oe_n <= host ? pin_oe_n_d : gp_oe_n_d;
      gp_in_q  <= gp_in_d;
      host_st  <= host_d;
    end
  end

  // Data lines: driven only during a host read, captured on writes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dat_out    <= '0;
      dat_oe_n   <= '1;
      host_wdata <= '0;
    end else begin
      dat_out  <= core_rd_data;
      dat_oe_n <= {HPF_DATA_W{~acc_rd}};
      if (acc_wr) begin
        host_wdata <= dat_s;
      end
    end
  end

  // Checks
  AST_RESET_DISCONNECTED: assert property (
    @(posedge sys_clk) $past(reset) |-> (pin_oe_n == '1) && !cfg_q.host_fn && (gp_in_q == '0))
    else $error("pins not disconnected after reset");

  AST_RESET_ACTIVE_LOW: assert property (
    @(posedge sys_clk) $past(reset) |->
      !cfg_q.rd_pol && !cfg_q.wr_pol && !cfg_q.ds_pol && !cfg_q.cs_pol && !cfg_q.as_pol)
    else $error("strobe polarity not active low after reset");

  AST_REQ_POL_RESET: assert property (
    @(posedge sys_clk) $past(reset) |-> !cfg_q.req_pol && !cfg_q.ack_pol)
    else $error("request or acknowledge not active low after reset");

  AST_HOST_INPUTS_UNDRIVEN: assert property (
    @(posedge sys_clk) disable iff (reset)
      $past(host) |-> (pin_oe_n[HPF_PIN_CS:0] == '1))
    else $error("host input pin driven");

  AST_SINGLE_REQ: assert property (
    @(posedge sys_clk) disable iff (reset)
      $past(host && !cfg_q.dual_req && !cfg_q.req_od) |->
        !pin_oe_n[HPF_PIN_REQ] && pin_oe_n[HPF_PIN_ACK] &&
        (pin_out[HPF_PIN_REQ] == ($past(cfg_q.req_pol) ~^ $past(core_req))))
    else $error("single request pin wrong");

  AST_DUAL_REQ: assert property (
    @(posedge sys_clk) disable iff (reset)
      $past(host && cfg_q.dual_req && !cfg_q.req_od) |->
        !pin_oe_n[HPF_PIN_ACK] && !host_st.ack &&
        (pin_out[HPF_PIN_ACK] == ($past(cfg_q.req_pol) ~^ $past(core_rx_req))))
    else $error("receive request pin wrong");

  AST_OPEN_DRAIN: assert property (
    @(posedge sys_clk) disable iff (reset)
      $past(host && cfg_q.req_od) |->
        !pin_out[HPF_PIN_REQ] && (pin_oe_n[HPF_PIN_REQ] == $past(lvl_a)))
    else $error("open drain request drives high");

  AST_GP_OUTPUT: assert property (
    @(posedge sys_clk) disable iff (reset)
      $past(!host && cfg_q.gp_dir[HPF_PIN_DS] == HPF_GP_OUT) |->
        !pin_oe_n[HPF_PIN_DS] && (pin_out[HPF_PIN_DS] == $past(cfg_q.gp_out[HPF_PIN_DS])))
    else $error("gpio output not driven");

  AST_SINGLE_STROBE_WRITE: assert property (
    @(posedge sys_clk) disable iff (reset)
      host_st.wr && $past(!cfg_q.dual_strobe) |-> !host_st.rnw)
    else $error("write decoded with read_not_write high");

  AST_MUX_ADDR_LATCH: assert property (
    @(posedge sys_clk) disable iff (reset)
      $past(host && cfg_q.mux_bus && as_act) |-> host_st.mux_addr == $past(dat_s))
    else $error("muxed address not latched");

  AST_SYNC_DELAY: assert property (
    @(posedge sys_clk) disable iff (reset)
      $past(host && cfg_q.mux_bus && cfg_q.dual_strobe && !cfg_q.rd_pol) ##0
      $past(cfg_q.rd_pol, 2) == 1'b0 ##0 $past(reset, 3) == 1'b0 |->
        host_st.rd == !$past(pin_in[HPF_PIN_RW], 3))
    else $error("read strobe not taken through synchroniser");

endmodule // hpf_pin_select

// [sim/hpf_host_model.sv]
`timescale 1ns/100ps
// Host side of the shared pins: resolves every wire from device and host drive
module hpf_host_model (
  input  wire logic [5:0] pin_out,   // Device drive values
  input  wire logic [5:0] pin_oe_n,  // Device enables, low drives
  input  wire logic [7:0] dat_out,   // Device data drive
  input  wire logic [7:0] dat_oe_n,  // Device data enables, low drives
  input  wire logic [5:0] h_en,      // Host drives this pin
  input  wire logic [5:0] h_lvl,     // Host level on driven pins
  input  wire logic       h_den,     // Host drives the data lines
  input  wire logic [7:0] h_dat,     // Host data byte
  output logic      [5:0] pin_in,    // Resolved pin levels
  output logic      [7:0] dat_in     // Resolved data levels
);
  // Device drive wins, then the host; undriven lines sit at their pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (h_en[i] ? h_lvl[i] : 1'b1);
    end
    for (int j = 0; j < 8; j++) begin
      dat_in[j] = !dat_oe_n[j] ? dat_out[j] : (h_den ? h_dat[j] : 1'b1);
    end
  end
endmodule // hpf_host_model

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench;
  import hpf_pkg::*;
  logic       sys_clk, reset, cfg_wr, as_in, h_den;            // Clock, reset, strobes
  hpf_cfg_t   cfg_in, cfg_q, c;                                // Configuration words
  logic       core_req, core_tx_req, core_rx_req;              // Core requests
  logic [7:0] core_rd_data, host_wdata, dat_in, dat_out, dat_oe_n, h_dat, d; // Data
  hpf_host_t  host_st;                                         // Decoded host activity
  logic [5:0] gp_in_q, pin_in, pin_out, pin_oe_n, h_en, h_lvl, eo, ep, eg; // Pins
  logic       dual, pol, od, mux, a, lv4, lv5;                 // Loop settings
  int         fails, cmp_count;                                // Result counters

  hpf_pin_select uut (.sys_clk, .reset, .cfg_wr, .cfg_in, .cfg_q, .core_req, .core_tx_req,
    .core_rx_req, .core_rd_data, .host_st, .host_wdata, .gp_in_q, .pin_in, .pin_out,
    .pin_oe_n, .dat_in, .dat_out, .dat_oe_n, .as_in);
  hpf_host_model host_m (.pin_out, .pin_oe_n, .dat_out, .dat_oe_n, .h_en, .h_lvl, .h_den,
    .h_dat, .pin_in, .dat_in);

  // Clock generator
  always #25 sys_clk = ~sys_clk;

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One-cycle configuration load, then room for the pins to follow
  task load(input hpf_cfg_t cv);
    cfg_in = cv;
    cfg_wr = 1'b1;
    wait_n(1);
    cfg_wr = 1'b0;
    wait_n(2);
  endtask

  // Host drives pins and data, then waits out the synchroniser
  task host(input logic [5:0] en, input logic [5:0] lv, input logic den,
            input logic [7:0] dv, input logic as);
    h_en = en;
    h_lvl = lv;
    h_den = den;
    h_dat = dv;
    as_in = as;
    wait_n(4);
  endtask

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #(3000 * 50);
    fails++;
    finish_test;
  end

  // Test sequence
  initial begin
    sys_clk = 0; reset = 1; cfg_wr = 0; cfg_in = '0; core_req = 0; core_tx_req = 0;
    core_rx_req = 0; core_rd_data = 8'h00; as_in = 1; h_en = 6'h3F; h_lvl = 6'h2A;
    h_den = 0; h_dat = 8'h00; fails = 0; cmp_count = 0;
    wait_n(20);
    check(pin_oe_n, 6'h3F);
    check(dat_oe_n, 8'hFF);
    check(cfg_q, 32'h0);
    reset = 0;
    wait_n(4);
    check(gp_in_q, 6'h00);
    check(host_st, 16'h0000);
    check(pin_oe_n, 6'h3F);
    $display("Reset test done");
    // Each pin visits every direction
    for (int k = 0; k < 3; k++) begin
      c = '0;
      c.gp_out = 6'h2D;
      h_lvl = 6'h36 ^ 6'(k);
      for (int i = 0; i < 6; i++) begin
        c.gp_dir[i] = hpf_gp_dir_t'((i + k) % 3);
        eo[i] = (c.gp_dir[i] != HPF_GP_OUT);
        ep[i] = (c.gp_dir[i] == HPF_GP_OUT) & c.gp_out[i];
        eg[i] = (c.gp_dir[i] == HPF_GP_IN) & h_lvl[i];
      end
      load(c);
      wait_n(4);
      check(pin_oe_n, eo);
      check(pin_out, ep);
      check(gp_in_q, eg);
    end
    $display("GPIO test done");
    // Request schemes, polarities and drive kinds
    for (int m = 0; m < 8; m++) begin
      {dual, pol, od} = 3'(m);
      c = '0;
      c.host_fn = 1;
      c.dual_req = dual;
      c.req_pol = pol;
      c.ack_pol = pol;
      c.req_od = od;
      load(c);
      for (int r = 0; r < 2; r++) begin
        core_req = dual ^ r[0];
        core_tx_req = !(dual ^ r[0]);
        core_rx_req = !r[0];
        lv4 = !(pol ^ r[0]);
        lv5 = pol ^ r[0];
        host(dual ? 6'h00 : 6'h20, {pol, 5'h00}, 1'b0, 8'h00, 1'b1);
        check(pin_oe_n[4], od & lv4);
        check(pin_out[4], !od & lv4);
        check(pin_oe_n[5], dual ? (od & lv5) : 1'b1);
        check(pin_out[5], dual & !od & lv5);
        check(host_st.ack, !dual);
      end
    end
    $display("Request test done");
    // Host bus decode over mux, strobe scheme and polarity
    for (int k = 0; k < 8; k++) begin
      {mux, dual, a} = 3'(k);
      c = '0;
      c.host_fn = 1;
      c.mux_bus = mux;
      c.dual_strobe = dual;
      {c.rd_pol, c.wr_pol, c.ds_pol, c.cs_pol, c.as_pol} = {5{a}};
      load(c);
      core_rd_data = 8'h3C + 8'(k);
      d = 8'hA5 ^ 8'(k);
      host(6'h0F, {2'b00, a, dual ? !a : a, dual ? a : 1'b1, 1'b1}, 1'b0, 8'h00, !a);
      check(host_st.rd, 1);
      check(host_st.wr, 0);
      check(host_st.rnw, !dual);
      check(host_st.addr_two, !mux);
      check(host_st.addr_nine, mux);
      check(host_st.addr_ten, mux & a);
      check(dat_oe_n, 8'h00);
      check(dat_out, core_rd_data);
      // Host ends the read and waits for the data lines to be released before it drives
      host(6'h0F, {2'b00, !a, !a, !a, 1'b1}, 1'b0, 8'h00, !a);
      check(host_st.rd, 0);
      check(dat_oe_n, 8'hFF);
      host(6'h0F, {2'b00, a, a, dual ? !a : 1'b0, 1'b0}, 1'b1, d, a);
      check(host_st.wr, 1);
      check(host_st.rd, 0);
      check(host_wdata, d);
      check(host_st.addr_two, 0);
      check(dat_oe_n, 8'hFF);
      if (mux)
        check(host_st.mux_addr, d);
      // Chip select inactive: only the muxed bus still decodes
      host(6'h0F, {2'b00, !a, dual ? !a : a, dual ? a : 1'b1, 1'b1}, 1'b0, 8'h00, !a);
      check(host_st.rd, mux);
      check(host_st.sel, mux);
    end
    $display("Host bus test done");
    finish_test;
  end
endmodule // testbench
